// File: verilog/e1ai_pkg.sv
// constants, register map and carrier types for the e1 receive alarm/interrupt block
// assumes a 25 MHz MCLK and status/strobe inputs synchronous to it
// Behaviour
// - all registers held reset when block disabled
// - interrupt on interworking or loss status change when enabled
// - interrupt when frame alignment position moves
// - separate enables for three alignment error events
// - interrupt on alarm status change when enabled
// - zero si bit frames 13/15 flags febe
// - crc mismatch sets crc error flag only while crc multiframe enabled
// - change flags set on both edges
// - error flags stay set until register read
// - flags latch regardless of enable bits
// - reading indication register clears it and interrupt
// - interworking state follows interworking mode
// - loss states follow alignment loss and regain
// - offline state set while offline framer hunts
// - a high, e low for 10 ms
// - e high over 990/1000 for 5 seconds
// - link id when two of three sa7 zero
// - remote alarm from a bit, criterion, four frames
// - multiframe alarm after three y ones
// - low density per 512 bits, criterion select
// - red after 100 ms loss, clears likewise
// - ais after 100 ms all-ones loss, clears likewise
// - crc multiframe disabled forces crc indications zero
package e1ai_pkg;
   localparam logic [7:0] ADR_ALM_EN = 8'h93;
   localparam logic [7:0] ADR_FRM_IND = 8'h94;
   localparam logic [7:0] ADR_ALM_IND = 8'h95;
   localparam logic [7:0] ADR_FRM_STS = 8'h96;
   localparam logic [7:0] ADR_ALM_STS = 8'h97;
   localparam logic [7:0] ALM_EN_RESET = 8'h00;
   // framing status / indication bit positions
   localparam int B_IW = 7;
   localparam int B_OOF = 6;
   localparam int B_OOSMF = 5;
   localparam int B_OOCMF = 4;
   localparam int B_MOVE = 3;
   localparam int B_FER = 2;
   localparam int B_SMFER = 1;
   localparam int B_CMFER = 0;
   // alarm status / indication bit positions
   localparam int B_RAI = 7;
   localparam int B_RMAI = 6;
   localparam int B_LOW_DENSITY_DETECT = 5;
   localparam int B_RED = 3;
   localparam int B_AIS = 2;
   localparam int B_FEBE = 1;
   localparam int B_CRCE = 0;
   // bits forced to zero while crc multiframing is off
   localparam logic [7:0] FRM_CRC_MASK = 8'h91;
   localparam logic [7:0] STS_CRC_MASK = 8'h96;
   localparam logic [7:0] ALM_CRC_MASK = 8'h03;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int T_MS_NS = 1000000;
   localparam int MS_CYCLES = T_MS_NS / CLK_PERIOD_NS;
   localparam int T_RAICCRC_MS = 10;
   localparam int T_PERSIST_MS = 100;
   localparam int T_SECOND_MS = 1000;
   localparam int FEBE_GOOD_MIN = 990;
   localparam int CFEBE_SECONDS = 5;
   localparam int AIS_PERIOD_BITS = 512;
   localparam int AIS_ZERO_LIMIT = 3;
   localparam int RAI_RUN = 4;
   localparam int RMAI_RUN = 3;

   typedef struct packed {
      logic frame_loss, sig_mf_loss, crc_mf_loss, interworking, offline_search;
      logic alignment_move, frame_error, sig_mf_error, crc_mf_error, crc_mismatch;
      logic nfas_strobe, a_bit;   // a bit once per nfas frame
      logic si_strobe, si_bit;    // e bit of frames 13 and 15
      logic y_strobe, y_bit;      // y bit once per signaling multiframe
      logic sa7_strobe, sa7_bit;
      logic bit_strobe, bit_data; // every received line bit
   } e1ai_rx_t;

   typedef struct packed {
      logic [7:0] alm_en, frm_ind, alm_ind, frm_sts, alm_sts, rdata;
      logic [15:0] ms_cnt;
      logic [1:0] a_run, y_run, zeros;
      logic [8:0] bit_cnt;
      logic low_prev, a_last, e_last;
      logic [9:0] sec_ms, e_hi;
      logic [2:0] good_secs, sa7_hist;
      logic [6:0] red_ms, ais_ms;
      logic [3:0] rc_ms;
   } e1ai_state_t;
endpackage : e1ai_pkg

// File: verilog/e1ai_core.sv
// e1 receive alarm detection, sticky indications and interrupt request
// assumes rx strobes are single-cycle and the register port is driven synchronously
module e1ai_core #(
   parameter int MS_CYC = e1ai_pkg::MS_CYCLES
) (
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic LINE_STANDARD_SELECT,
   input wire logic UNFRAMED_OPTION,
   input wire logic CRC_MULTIFRAME_ENABLE,
   input wire logic REMOTE_ALARM_CRITERION,
   input wire logic LOW_DENSITY_CRITERION,
   input wire logic [7:0] FRAMING_INT_EN,
   input wire e1ai_pkg::e1ai_rx_t RX,
   input wire logic [7:0] ADDR,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] WDATA,
   output logic [7:0] RDATA,
   output logic INTERRUPT_REQUEST_N
);
   import e1ai_pkg::*;

   if (MS_CYC < 1 || MS_CYC > 65535) begin : g_bad_ms
      $error("MS_CYC out of range");
   end

   e1ai_state_t s_r, s_nxt;
   logic hold, tick, crc_multiframe_enable, low, sec_end;
   logic [7:0] fs, as, set_f, set_a;
   logic [1:0] zeros_now;
   logic [7:0] red_step, ais_step;

   ////////////////////////////////////////////////////////////////
   // persistence timer: state flips after cond differs for T_PERSIST_MS ms
   function automatic logic [7:0] persist(input logic cond, input logic st, input logic [6:0] cnt,
                                          input logic tk);
      logic [6:0] c;
      c = cnt;
      if (cond == st) begin
         return {st, 7'h00};
      end
      if (tk) begin
         c = cnt + 7'h01;
      end
      if (c == 7'(T_PERSIST_MS)) begin
         return {cond, 7'h00};
      end
      return {st, c};
   endfunction : persist

   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      hold = !LINE_STANDARD_SELECT || UNFRAMED_OPTION;
      crc_multiframe_enable = CRC_MULTIFRAME_ENABLE;
      tick = (s_r.ms_cnt == 16'(MS_CYC - 1));
      s_nxt.ms_cnt = tick ? 16'h0000 : s_r.ms_cnt + 16'h0001;

      // raicc: a high and e low held for 10 ms
      if (!(s_r.a_last && !s_r.e_last && crc_multiframe_enable)) begin
         s_nxt.rc_ms = 4'h0;
      end else if (tick && s_r.rc_ms != 4'(T_RAICCRC_MS)) begin
         s_nxt.rc_ms = s_r.rc_ms + 4'h1;
      end

      // continuous febe: count e=1 per second, then a run of good seconds
      sec_end = tick && (s_r.sec_ms == 10'(T_SECOND_MS - 1));
      if (RX.si_strobe) begin
         s_nxt.e_last = RX.si_bit;
         if (RX.si_bit && s_r.e_hi != 10'h3ff) begin
            s_nxt.e_hi = s_r.e_hi + 10'h001;
         end
      end
      if (tick) begin
         s_nxt.sec_ms = sec_end ? 10'h000 : s_r.sec_ms + 10'h001;
      end
      if (sec_end) begin
         if (s_r.e_hi > 10'(FEBE_GOOD_MIN)) begin
            if (s_r.good_secs != 3'(CFEBE_SECONDS)) begin
               s_nxt.good_secs = s_r.good_secs + 3'h1;
            end
         end else begin
            s_nxt.good_secs = 3'h0;
         end
         s_nxt.e_hi = 10'h000;
      end

      // link id: majority of zeros in the last three sa7 bits
      if (RX.sa7_strobe) begin
         s_nxt.sa7_hist = {s_r.sa7_hist[1:0], RX.sa7_bit};
      end

      // remote alarm, sampled on each nfas frame (every two frames)
      if (RX.nfas_strobe) begin
         s_nxt.a_last = RX.a_bit;
         if (RX.a_bit) begin
            s_nxt.alm_sts[B_RAI] = s_r.alm_sts[B_RAI] || !REMOTE_ALARM_CRITERION
                                   || (s_r.a_run == 2'(RAI_RUN - 1));
            s_nxt.a_run = (s_r.a_run == 2'h3) ? 2'h3 : s_r.a_run + 2'h1;
         end else begin
            s_nxt.alm_sts[B_RAI] = 1'b0;
            s_nxt.a_run = 2'h0;
         end
      end

      // remote multiframe alarm, once per signaling multiframe (16 frames)
      if (RX.y_strobe) begin
         if (RX.y_bit) begin
            s_nxt.alm_sts[B_RMAI] = s_r.alm_sts[B_RMAI] || (s_r.y_run == 2'(RMAI_RUN - 1));
            s_nxt.y_run = (s_r.y_run == 2'h3) ? 2'h3 : s_r.y_run + 2'h1;
         end else begin
            s_nxt.alm_sts[B_RMAI] = 1'b0;
            s_nxt.y_run = 2'h0;
         end
      end

      // low density: zeros counted, saturating at the limit, per 512-bit period
      zeros_now = s_r.zeros;
      low = 1'b0;
      if (RX.bit_strobe) begin
         if (!RX.bit_data && s_r.zeros != 2'(AIS_ZERO_LIMIT)) begin
            zeros_now = s_r.zeros + 2'h1;
         end
         s_nxt.zeros = zeros_now;
         s_nxt.bit_cnt = s_r.bit_cnt + 9'h001;
         if (s_r.bit_cnt == 9'(AIS_PERIOD_BITS - 1)) begin
            low = (zeros_now < 2'(AIS_ZERO_LIMIT));
            if (!LOW_DENSITY_CRITERION || low == s_r.low_prev) begin
               s_nxt.alm_sts[B_LOW_DENSITY_DETECT] = low;
            end
            s_nxt.low_prev = low;
            s_nxt.zeros = 2'h0;
         end
      end

      // red and ais persistence, timed in ms ticks
      red_step = persist(RX.frame_loss, s_r.alm_sts[B_RED], s_r.red_ms, tick);
      ais_step = persist(RX.frame_loss && s_r.alm_sts[B_LOW_DENSITY_DETECT], s_r.alm_sts[B_AIS], s_r.ais_ms, tick);
      s_nxt.alm_sts[B_RED] = red_step[7];
      s_nxt.red_ms = red_step[6:0];
      s_nxt.alm_sts[B_AIS] = ais_step[7];
      s_nxt.ais_ms = ais_step[6:0];
      as = s_nxt.alm_sts;

      // framing status mirrors the aligner, crc-related bits gated off
      fs = {RX.interworking, RX.frame_loss, RX.sig_mf_loss, RX.crc_mf_loss,
            RX.offline_search, s_r.rc_ms == 4'(T_RAICCRC_MS),
            s_r.good_secs == 3'(CFEBE_SECONDS),
            (!s_r.sa7_hist[0] && !s_r.sa7_hist[1]) || (!s_r.sa7_hist[0] && !s_r.sa7_hist[2])
            || (!s_r.sa7_hist[1] && !s_r.sa7_hist[2])};
      if (!crc_multiframe_enable) begin
         fs = fs & ~STS_CRC_MASK;
      end
      s_nxt.frm_sts = fs;

      // sticky events: change of either polarity or single error events
      set_f = {(fs[7:4] ^ s_r.frm_sts[7:4]), RX.alignment_move, RX.frame_error,
               RX.sig_mf_error, RX.crc_mf_error};
      set_a = {(as[7:5] ^ s_r.alm_sts[7:5]), 1'b0, (as[3:2] ^ s_r.alm_sts[3:2]),
               RX.si_strobe && !RX.si_bit, RX.crc_mismatch};
      if (!crc_multiframe_enable) begin
         set_f = set_f & ~FRM_CRC_MASK;
         set_a = set_a & ~ALM_CRC_MASK;
      end

      // a read clears, but an event in the same cycle wins
      s_nxt.frm_ind = ((RD && ADDR == ADR_FRM_IND) ? 8'h00 : s_r.frm_ind) | set_f;
      s_nxt.alm_ind = ((RD && ADDR == ADR_ALM_IND) ? 8'h00 : s_r.alm_ind) | set_a;
      if (!crc_multiframe_enable) begin
         s_nxt.frm_ind = s_nxt.frm_ind & ~FRM_CRC_MASK;
         s_nxt.alm_ind = s_nxt.alm_ind & ~ALM_CRC_MASK;
      end

      // register port; reserved enable bit stored as written, kept 0 by software
      if (WR && ADDR == ADR_ALM_EN) begin
         s_nxt.alm_en = WDATA;
      end
      if (RD) begin
         case (ADDR)
            ADR_ALM_EN: s_nxt.rdata = s_r.alm_en;
            ADR_FRM_IND: s_nxt.rdata = s_r.frm_ind;
            ADR_ALM_IND: s_nxt.rdata = s_r.alm_ind;
            ADR_FRM_STS: s_nxt.rdata = s_r.frm_sts;
            ADR_ALM_STS: s_nxt.rdata = s_r.alm_sts & 8'hec;
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      // block disabled: everything held in reset
      if (hold) begin
         s_nxt = '0;
         s_nxt.alm_en = ALM_EN_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // request follows flags directly so a clearing read drops it at once
   assign RDATA = s_r.rdata;
   assign INTERRUPT_REQUEST_N = !(|(s_r.frm_ind & FRAMING_INT_EN) | |(s_r.alm_ind & s_r.alm_en));

   ////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);

   sequence rai_fast_s;
      !hold && !REMOTE_ALARM_CRITERION && RX.nfas_strobe && RX.a_bit;
   endsequence
   sequence febe_zero_s;
      !hold && crc_multiframe_enable && RX.si_strobe && !RX.si_bit;
   endsequence

   a_hold_clears: assert property (hold |=> s_r.frm_ind == 8'h00 && s_r.alm_en == 8'h00)
      else $error("registers not held while disabled");
   a_oof_change: assert property (!hold && RX.frame_loss != s_r.frm_sts[B_OOF] |=> s_r.frm_ind[B_OOF])
      else $error("frame loss change not flagged");
   a_align_move: assert property (!hold && RX.alignment_move |=> s_r.frm_ind[B_MOVE])
      else $error("alignment move not flagged");
   a_frame_err: assert property (!hold && RX.frame_error |=> s_r.frm_ind[B_FER] until_with
                                 ((RD && ADDR == ADR_FRM_IND) || hold))
      else $error("frame error flag lost before read");
   a_febe_flag: assert property (febe_zero_s |=> s_r.alm_ind[B_FEBE])
      else $error("febe not flagged");
   a_crc_flag: assert property (!hold && crc_multiframe_enable && RX.crc_mismatch |=> s_r.alm_ind[B_CRCE])
      else $error("crc mismatch not flagged");
   a_read_clear: assert property (!hold && RD && ADDR == ADR_ALM_IND && set_a == 8'h00
                                  |=> s_r.alm_ind == 8'h00
                                  && (INTERRUPT_REQUEST_N || |(s_r.frm_ind & FRAMING_INT_EN)))
      else $error("read did not clear alarm flags");
   a_irq_pending: assert property (s_r.frm_ind[B_OOF] && FRAMING_INT_EN[B_OOF] |-> !INTERRUPT_REQUEST_N)
      else $error("pending enabled flag without request");
   a_rai_fast: assert property (rai_fast_s |=> s_r.alm_sts[B_RAI])
      else $error("remote alarm not set on a=1");
   a_crc_forced: assert property (!crc_multiframe_enable |=> s_r.frm_sts[B_OOCMF] == 1'b0 && s_r.frm_ind[B_IW] == 1'b0)
      else $error("crc indications not forced off");
endmodule : e1ai_core

// File: sim/e1ai_host_model.sv
// microprocessor model driving the block's 8-bit register port
// assumes the block samples wr/rd with addr at rising mclk and updates rdata on that edge
module e1ai_host_model (
   input wire logic mclk,
   input wire logic [7:0] rdata,
   output logic [7:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one write cycle; the reserved enable bit is never set by this host
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d & 8'hef;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      addr <= ~a; // released bus shows a changing pattern, not the last value
      wdata <= ~d;
   endtask : wr_reg
   // one read cycle; data is taken one edge after the sampling edge, while it stands
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      addr <= ~a;
      @(posedge mclk);
      d = rdata;
   endtask : rd_reg
endmodule : e1ai_host_model

// File: sim/test_e1_framer_alarm_interrupts.sv
// self-checking bench for the e1 alarm/interrupt block
// assumes a shortened millisecond count so the 100 ms persistence checks stay short
module test_e1_framer_alarm_interrupts;
   timeunit 1ns;
   timeprecision 1ps;
   import e1ai_pkg::*;
   localparam int MSC = 10;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic std_sel = 1'b1, unf = 1'b0, crc_en = 1'b1, rai_crit = 1'b0, ld_crit = 1'b0;
   logic [7:0] frm_en = 8'h00;
   e1ai_rx_t rx = '0;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, irq_n;
   int miscompares = 0;
   int n_compared = 0;
   // 25 MHz clock
   always #20 mclk = ~mclk;
   e1ai_core #(.MS_CYC(MSC)) dut (.MCLK(mclk), .RESET(reset), .LINE_STANDARD_SELECT(std_sel),
      .UNFRAMED_OPTION(unf), .CRC_MULTIFRAME_ENABLE(crc_en), .REMOTE_ALARM_CRITERION(rai_crit),
      .LOW_DENSITY_CRITERION(ld_crit), .FRAMING_INT_EN(frm_en), .RX(rx), .ADDR(addr), .WR(wr),
      .RD(rd), .WDATA(wdata), .RDATA(rdata), .INTERRUPT_REQUEST_N(irq_n));
   e1ai_host_model host (.mclk(mclk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_irq(input logic exp);
      n_compared++;
      if (irq_n !== exp) begin
         miscompares++;
         $display("mismatch irq_n expected %b seen %b", exp, irq_n);
      end
   endtask : chk_irq
   // masked read so unrelated live status bits do not disturb the check
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] d;
      host.rd_reg(a, d);
      chk(what, exp, d & m);
   endtask : rd_chk
   task automatic nfas(input logic a);
      rx.nfas_strobe <= 1'b1;
      rx.a_bit <= a;
      cyc(1);
      rx.nfas_strobe <= 1'b0;
      cyc(1);
   endtask : nfas
   task automatic ymf(input logic y);
      rx.y_strobe <= 1'b1;
      rx.y_bit <= y;
      cyc(1);
      rx.y_strobe <= 1'b0;
      cyc(1);
   endtask : ymf
   task automatic sa7(input logic b);
      rx.sa7_strobe <= 1'b1;
      rx.sa7_bit <= b;
      cyc(1);
      rx.sa7_strobe <= 1'b0;
      cyc(1);
   endtask : sa7
   // exactly one 512-bit period of line bits, so periods stay aligned between bursts
   task automatic burst(input logic d);
      rx.bit_strobe <= 1'b1;
      rx.bit_data <= d;
      cyc(AIS_PERIOD_BITS);
      rx.bit_strobe <= 1'b0;
   endtask : burst
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_registers;
      chk_irq(1'b1);
      rd_chk("enable reset", ADR_ALM_EN, 8'hff, ALM_EN_RESET);
      rd_chk("unmapped", 8'h98, 8'hff, 8'h00);
      host.wr_reg(ADR_ALM_EN, 8'hff);
      rd_chk("enable rw", ADR_ALM_EN, 8'hff, 8'hef);
      host.wr_reg(ADR_FRM_IND, 8'hff);
      rd_chk("ind not writable", ADR_FRM_IND, 8'hff, 8'h00);
      unf <= 1'b1;
      cyc(2);
      unf <= 1'b0;
      rd_chk("unframed reset", ADR_ALM_EN, 8'hff, 8'h00);
      $display("test registers done");
   endtask : t_registers
   task automatic t_change;
      frm_en <= 8'h40;
      rx.frame_loss <= 1'b1;
      cyc(2);
      chk_irq(1'b0);
      rd_chk("loss state", ADR_FRM_STS, 8'h40, 8'h40);
      rd_chk("rise flag", ADR_FRM_IND, 8'hff, 8'h40);
      chk_irq(1'b1);
      rd_chk("flag cleared", ADR_FRM_IND, 8'hff, 8'h00);
      rx.frame_loss <= 1'b0;
      cyc(2);
      chk_irq(1'b0);
      rd_chk("regained", ADR_FRM_STS, 8'h40, 8'h00);
      rd_chk("fall flag", ADR_FRM_IND, 8'hff, 8'h40);
      frm_en <= 8'h00;
      $display("test change done");
   endtask : t_change
   task automatic t_events;
      repeat (2) begin
         rx.frame_error <= 1'b1;
         cyc(1);
         rx.frame_error <= 1'b0;
         cyc(1);
      end
      rx.alignment_move <= 1'b1;
      frm_en <= 8'h08;
      cyc(1);
      rx.alignment_move <= 1'b0;
      rx.frame_error <= 1'b1;
      cyc(1);
      rx.frame_error <= 1'b0;
      cyc(1);
      chk_irq(1'b0);
      rd_chk("polled errors", ADR_FRM_IND, 8'hff, 8'h0c);
      chk_irq(1'b1);
      frm_en <= 8'h00;
      host.wr_reg(ADR_ALM_EN, 8'h01);
      rx.si_strobe <= 1'b1;
      rx.si_bit <= 1'b0;
      cyc(1);
      rx.si_strobe <= 1'b0;
      cyc(1);
      chk_irq(1'b1);
      rx.crc_mismatch <= 1'b1;
      cyc(1);
      rx.crc_mismatch <= 1'b0;
      cyc(1);
      chk_irq(1'b0);
      rd_chk("febe crc flags", ADR_ALM_IND, 8'h03, 8'h03);
      crc_en <= 1'b0;
      rx.crc_mismatch <= 1'b1;
      cyc(1);
      rx.crc_mismatch <= 1'b0;
      rd_chk("crc off", ADR_ALM_IND, 8'h03, 8'h00);
      crc_en <= 1'b1;
      $display("test events done");
   endtask : t_events
   task automatic t_remote;
      rai_crit <= 1'b1;
      repeat (3) nfas(1'b1);
      rd_chk("three ones", ADR_ALM_STS, 8'h80, 8'h00);
      nfas(1'b1);
      rd_chk("four ones", ADR_ALM_STS, 8'h80, 8'h80);
      nfas(1'b0);
      rd_chk("a zero", ADR_ALM_STS, 8'h80, 8'h00);
      rai_crit <= 1'b0;
      nfas(1'b1);
      rd_chk("single one", ADR_ALM_STS, 8'h80, 8'h80);
      rd_chk("rai flag", ADR_ALM_IND, 8'h80, 8'h80);
      $display("test remote done");
   endtask : t_remote
   task automatic t_red;
      rx.frame_loss <= 1'b1;
      cyc(97 * MSC);
      rd_chk("red early", ADR_ALM_STS, 8'h08, 8'h00);
      cyc(4 * MSC);
      rd_chk("red set", ADR_ALM_STS, 8'h08, 8'h08);
      rx.frame_loss <= 1'b0;
      cyc(97 * MSC);
      rd_chk("red held", ADR_ALM_STS, 8'h08, 8'h08);
      cyc(4 * MSC);
      rd_chk("red clear", ADR_ALM_STS, 8'h08, 8'h00);
      rd_chk("red flag", ADR_ALM_IND, 8'h08, 8'h08);
      $display("test red done");
   endtask : t_red
   task automatic t_density;
      burst(1'b1);
      rd_chk("quiet period", ADR_ALM_STS, 8'h20, 8'h20);
      rx.frame_loss <= 1'b1;
      cyc(97 * MSC);
      rd_chk("ais early", ADR_ALM_STS, 8'h04, 8'h00);
      cyc(4 * MSC);
      rd_chk("ais set", ADR_ALM_STS, 8'h04, 8'h04);
      rx.frame_loss <= 1'b0;
      burst(1'b0);
      rd_chk("zeros period", ADR_ALM_STS, 8'h20, 8'h00);
      ld_crit <= 1'b1;
      burst(1'b1);
      rd_chk("one quiet period", ADR_ALM_STS, 8'h20, 8'h00);
      burst(1'b1);
      rd_chk("two quiet periods", ADR_ALM_STS, 8'h20, 8'h20);
      burst(1'b0);
      rd_chk("one zeros period", ADR_ALM_STS, 8'h20, 8'h20);
      ld_crit <= 1'b0;
      rd_chk("density flags", ADR_ALM_IND, 8'h24, 8'h24);
      $display("test density done");
   endtask : t_density
   task automatic t_status;
      nfas(1'b0);
      rd_chk("clean crc off", ADR_FRM_STS, 8'h04, 8'h00);
      nfas(1'b1);
      cyc(8 * MSC);
      rd_chk("clean crc early", ADR_FRM_STS, 8'h04, 8'h00);
      cyc(3 * MSC);
      rd_chk("clean crc set", ADR_FRM_STS, 8'h04, 8'h04);
      rx.interworking <= 1'b1;
      rx.offline_search <= 1'b1;
      cyc(2);
      rd_chk("interworking offline", ADR_FRM_STS, 8'h88, 8'h88);
      rx.interworking <= 1'b0;
      rx.offline_search <= 1'b0;
      cyc(2);
      rd_chk("left interworking", ADR_FRM_STS, 8'h88, 8'h00);
      rd_chk("interworking flag", ADR_FRM_IND, 8'h80, 8'h80);
      ymf(1'b1);
      ymf(1'b1);
      rd_chk("two y ones", ADR_ALM_STS, 8'h40, 8'h00);
      ymf(1'b1);
      rd_chk("three y ones", ADR_ALM_STS, 8'h40, 8'h40);
      ymf(1'b0);
      rd_chk("y zero", ADR_ALM_STS, 8'h40, 8'h00);
      repeat (3) sa7(1'b1);
      rd_chk("link ones", ADR_FRM_STS, 8'h01, 8'h00);
      sa7(1'b0);
      rd_chk("link one zero", ADR_FRM_STS, 8'h01, 8'h00);
      sa7(1'b0);
      rd_chk("link two zeros", ADR_FRM_STS, 8'h01, 8'h01);
      $display("test status done");
   endtask : t_status
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   // watchdog: the tests need about 5900 cycles
   initial begin
      cyc(20000);
      miscompares++;
      $display("watchdog expired");
      final_report();
   end
   initial begin
      cyc(6);
      reset <= 1'b0;
      t_registers();
      t_change();
      t_events();
      t_remote();
      t_red();
      t_density();
      t_status();
      final_report();
   end
endmodule : test_e1_framer_alarm_interrupts
